/* rtl/host_pins_pkg.sv */
// Purpose: Shared constants for the per-channel host strobe, modem pin and request logic
// Assumes: Eight registers per channel, selected by three address bits
// Notes: Offsets of the modem control, event enable and modem status registers are local

package host_pins_pkg;

    // Register offsets inside one channel
    localparam logic [2:0] EVENT_ENABLE_OFS = 3'h1;
    localparam logic [2:0] MODEM_CTRL_OFS = 3'h4;
    localparam logic [2:0] MODEM_STAT_OFS = 3'h6;

    // Field positions
    localparam int MCR_TERM_READY_BIT = 0;
    localparam int MCR_REQ_ENABLE_BIT = 3;
    localparam int MSR_DATASET_READY_BIT = 5;
    localparam int EVENT_COUNT = 4;

    // Reset values
    localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
    localparam logic [3:0] EVENT_ENABLE_RST = 4'h0;
    localparam logic [7:0] DATA_OUT_RST = 8'h00;

    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;

    // Bus modes
    typedef enum logic {
        MODE_RW_LINE = 1'b0,
        MODE_STROBE = 1'b1
    } bus_mode_e;

endpackage : host_pins_pkg

/* rtl/host_pins_top.sv */
// Purpose: Host strobes, terminal/dataset ready and service request pins of a multi-channel UART
// Assumes: All pins are asynchronous to clk_sys; event inputs come from logic on clk_sys
// Notes: One access per detected strobe edge; read data is held while the access stays open

`timescale 1ns/10ps
`default_nettype none

module host_pins_top #(
    parameter int NUM_CHAN = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic bus_mode_strobe,
    input wire logic [NUM_CHAN-1:0] chan_select_n,
    input wire logic [2:0] reg_addr,
    input wire logic [1:0] chan_addr,
    input wire logic host_rd_strobe_n,
    input wire logic host_wr_strobe_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic req_force_sel,
    input wire logic [NUM_CHAN-1:0] dataset_ready_n,
    output logic [NUM_CHAN-1:0] terminal_ready_n,
    input wire logic [NUM_CHAN*host_pins_pkg::EVENT_COUNT-1:0] chan_events,
    output logic [NUM_CHAN-1:0] chan_service_req,
    output logic [NUM_CHAN-1:0] chan_service_req_oe,
    output logic shared_req_n,
    output logic shared_req_oe
);
    import host_pins_pkg::*;

    localparam int PIN_W = 1 + NUM_CHAN + 3 + 2 + 1 + 1 + 8 + 1 + NUM_CHAN;
    // Pin idle levels in reset: all high except the pulled-down force select
    localparam logic [PIN_W-1:0] PIN_IDLE = ~({{(PIN_W-1){1'b0}}, 1'b1} << NUM_CHAN);

    // Elaboration check: channel select in read/write-line mode is two bits
    if (NUM_CHAN < 1 || NUM_CHAN > 4) begin : g_chan_check
        $error("NUM_CHAN must be 1 to 4");
    end

    logic [1:0] rst_sync_q;
    logic rst_int_n;
    logic [PIN_W-1:0] pin_meta_q;
    logic [PIN_W-1:0] pin_sync_q;
    logic mode_strobe;
    logic [NUM_CHAN-1:0] cs_n_s;
    logic [2:0] addr_s;
    logic [1:0] chan_addr_s;
    logic rd_n_s;
    logic wr_n_s;
    logic force_s;
    logic [7:0] data_s;
    logic [NUM_CHAN-1:0] dsr_n_s;
    logic rd_n_prev_q;
    logic wr_n_prev_q;
    logic cs0_n_prev_q;
    logic rd_fall;
    logic wr_fall;
    logic rw_fall;
    logic [NUM_CHAN-1:0] wr_hit;
    logic [NUM_CHAN-1:0] rd_hit;
    logic [7:0] modem_ctrl_reg_q [NUM_CHAN];
    logic [EVENT_COUNT-1:0] event_enable_reg_q [NUM_CHAN];
    logic [NUM_CHAN-1:0] pending;
    logic [7:0] rd_mux;
    logic rd_any;
    logic access_open;

    // Reset release through two flip-flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_int_n = rst_sync_q[1];

    // Two-stage synchroniser on every pin input
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            pin_meta_q <= PIN_IDLE;
            pin_sync_q <= PIN_IDLE;
        end else begin
            pin_meta_q <= {bus_mode_strobe, chan_select_n, reg_addr, chan_addr, host_rd_strobe_n,
                           host_wr_strobe_n, data_in, req_force_sel, dataset_ready_n};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Split the synchronised pins
    assign {mode_strobe, cs_n_s, addr_s, chan_addr_s, rd_n_s, wr_n_s, data_s, force_s,
            dsr_n_s} = pin_sync_q;

    // Edge history for the strobes and the shared chip select
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            rd_n_prev_q <= 1'b1;
            wr_n_prev_q <= 1'b1;
            cs0_n_prev_q <= 1'b1;
        end else begin
            rd_n_prev_q <= rd_n_s;
            wr_n_prev_q <= wr_n_s;
            cs0_n_prev_q <= cs_n_s[0];
        end
    end

    // One access per falling edge; read strobe only counts in strobe mode
    assign rd_fall = (mode_strobe == MODE_STROBE) && rd_n_prev_q && !rd_n_s;
    assign wr_fall = (mode_strobe == MODE_STROBE) && wr_n_prev_q && !wr_n_s;
    assign rw_fall = (mode_strobe == MODE_RW_LINE) && cs0_n_prev_q && !cs_n_s[0];

    // Channel hit decode for both bus modes
    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            wr_hit[i] = (wr_fall && !cs_n_s[i])
                || (rw_fall && !wr_n_s && chan_addr_s == 2'(i));
            rd_hit[i] = (rd_fall && !cs_n_s[i])
                || (rw_fall && wr_n_s && chan_addr_s == 2'(i));
        end
    end

    // Per-channel modem control and event enable registers
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                modem_ctrl_reg_q[i] <= MODEM_CTRL_RST;
                event_enable_reg_q[i] <= EVENT_ENABLE_RST;
            end
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (wr_hit[i] && addr_s == MODEM_CTRL_OFS) begin
                    modem_ctrl_reg_q[i] <= data_s;
                end
                if (wr_hit[i] && addr_s == EVENT_ENABLE_OFS) begin
                    event_enable_reg_q[i] <= data_s[EVENT_COUNT-1:0];
                end
            end
        end
    end

    // Terminal ready follows control bit 0, inverted; high out of reset
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            terminal_ready_n <= '1;
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (wr_hit[i] && addr_s == MODEM_CTRL_OFS) begin
                    terminal_ready_n[i] <= !data_s[MCR_TERM_READY_BIT];
                end
            end
        end
    end

    // Read multiplexer: registers of the addressed channel, zero elsewhere
    always_comb begin
        rd_mux = 8'h00;
        rd_any = |rd_hit;
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (rd_hit[i]) begin
                unique case (addr_s)
                    MODEM_CTRL_OFS: rd_mux = modem_ctrl_reg_q[i];
                    EVENT_ENABLE_OFS: rd_mux = {4'h0, event_enable_reg_q[i]};
                    MODEM_STAT_OFS: rd_mux = 8'(!dsr_n_s[i]) << MSR_DATASET_READY_BIT;
                    default: rd_mux = 8'h00;
                endcase
            end
        end
    end

    // A read access stays open while its read strobe, or its select with the direction line high, is held low
    assign access_open = (mode_strobe == MODE_STROBE) ? !rd_n_s : (!cs_n_s[0] && wr_n_s);

    // Data bus drive: load on the edge, hold while the access is open
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            data_out <= DATA_OUT_RST;
            data_oe <= 1'b0;
        end else if (rd_any) begin
            data_out <= rd_mux;
            data_oe <= 1'b1;
        end else if (!access_open) begin
            data_oe <= 1'b0;
        end
    end

    // Pending events gated by the enable register
    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            pending[i] = |(chan_events[i*EVENT_COUNT +: EVENT_COUNT]
                           & event_enable_reg_q[i]);
        end
    end

    // Service request outputs, recomputed every cycle
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            chan_service_req <= '0;
            chan_service_req_oe <= '0;
            shared_req_n <= 1'b0;
            shared_req_oe <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                chan_service_req[i] <= modem_ctrl_reg_q[i][MCR_REQ_ENABLE_BIT]
                    && pending[i];
                chan_service_req_oe[i] <= (mode_strobe == MODE_STROBE)
                    && (force_s || modem_ctrl_reg_q[i][MCR_REQ_ENABLE_BIT]);
            end
            shared_req_n <= 1'b0;
            shared_req_oe <= (mode_strobe == MODE_RW_LINE) && (|pending);
        end
    end

endmodule : host_pins_top

`default_nettype wire

/* verification/host_pins_chk.sv */
// Purpose: Port checker for host_pins_top
// Assumes: Channel 0 carries host traffic
// Notes: Bound at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module host_pins_chk #(
    parameter int NUM_CHAN = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic bus_mode_strobe,
    input wire logic [NUM_CHAN-1:0] chan_select_n,
    input wire logic [2:0] reg_addr,
    input wire logic host_rd_strobe_n,
    input wire logic host_wr_strobe_n,
    input wire logic [7:0] data_in,
    input wire logic data_oe,
    input wire logic req_force_sel,
    input wire logic [NUM_CHAN-1:0] terminal_ready_n,
    input wire logic [NUM_CHAN*host_pins_pkg::EVENT_COUNT-1:0] chan_events,
    input wire logic [NUM_CHAN-1:0] chan_service_req,
    input wire logic [NUM_CHAN-1:0] chan_service_req_oe,
    input wire logic shared_req_n,
    input wire logic shared_req_oe
);
    import host_pins_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Strobe edges on channel 0
    sequence s_rd; $fell(host_rd_strobe_n) && bus_mode_strobe && !chan_select_n[0]; endsequence
    sequence s_wr; $fell(host_wr_strobe_n) && bus_mode_strobe && !chan_select_n[0]
        && reg_addr == MODEM_CTRL_OFS; endsequence
    // Reset held over two edges has taken effect on the ready outputs
    a_reset_ready: assert property (disable iff (1'b0) (!rst_n ##1 !rst_n) |-> &terminal_ready_n)
        else $error("ready low in reset");
    a_rd_answer: assert property (s_rd |-> ##[2:4] data_oe)
        else $error("no read answer");
    a_wr_set: assert property (s_wr ##0 data_in[0] |-> ##[2:4] !terminal_ready_n[0])
        else $error("ready not driven low");
    a_wr_clear: assert property (s_wr ##0 !data_in[0] |-> ##[2:4] terminal_ready_n[0])
        else $error("ready not driven high");
    a_req_cause: assert property (chan_service_req[0] |-> $past(|chan_events[3:0]))
        else $error("request without event");
    a_rw_no_oe: assert property ((!bus_mode_strobe)[*5] |-> chan_service_req_oe == '0)
        else $error("channel driver on in rw mode");
    a_force_oe: assert property ((bus_mode_strobe && req_force_sel)[*5] |-> &chan_service_req_oe)
        else $error("forced driver off");
    a_shared_low: assert property (shared_req_oe |-> !shared_req_n && $past(|chan_events))
        else $error("bad shared request");
endmodule : host_pins_chk
bind host_pins_top host_pins_chk #(.NUM_CHAN(NUM_CHAN)) chk_i (.clk_sys, .rst_n, .bus_mode_strobe,
    .chan_select_n, .reg_addr, .host_rd_strobe_n, .host_wr_strobe_n, .data_in, .data_oe,
    .req_force_sel, .terminal_ready_n, .chan_events, .chan_service_req, .chan_service_req_oe,
    .shared_req_n, .shared_req_oe);
`default_nettype wire

/* verification/modem_model.sv */
// Purpose: Modem pins and board pull-down
// Assumes: Bench sets power state per channel
// Notes: Select line floats unless driven
`timescale 1ns/10ps
`default_nettype none
module modem_model #(
    parameter int NUM_CHAN = 4
) (
    input wire logic [NUM_CHAN-1:0] powered,
    input wire logic force_drv,
    output logic [NUM_CHAN-1:0] dataset_ready_n,
    output logic req_force_sel
);
    // Ready low while powered; floating select reads 0
    assign dataset_ready_n = ~powered;
    assign req_force_sel = (force_drv === 1'b1);
endmodule : modem_model
`default_nettype wire

/* verification/host_pins_top_tb.sv */
// Purpose: Self-checking bench for host_pins_top
// Assumes: Channel 0 carries all traffic except the final read/write-line write, which targets channel 1
// Notes: Seeded random register data and masks
`timescale 1ns/10ps
`default_nettype none
module host_pins_top_tb;
    import host_pins_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, bus_mode_strobe = 1'b1, force_drv = 1'bz;
    logic host_rd_strobe_n = 1'b1, host_wr_strobe_n = 1'b1;
    logic [3:0] chan_select_n = 4'hf, powered = 4'h0;
    logic [2:0] reg_addr = 3'h0;
    logic [1:0] chan_addr = 2'h0;
    logic [7:0] data_in = 8'h00, q;
    logic [15:0] chan_events = 16'h0;
    wire logic [3:0] dataset_ready_n, terminal_ready_n, chan_service_req, chan_service_req_oe;
    wire logic [7:0] data_out;
    wire logic data_oe, shared_req_n, shared_req_oe, req_force_sel;
    int error_cnt = 0, check_count = 0;
    always #5 clk_sys = ~clk_sys;
    host_pins_top #(.NUM_CHAN(4)) uut (.clk_sys, .rst_n, .bus_mode_strobe, .chan_select_n,
        .reg_addr, .chan_addr, .host_rd_strobe_n, .host_wr_strobe_n, .data_in, .data_out,
        .data_oe, .req_force_sel, .dataset_ready_n, .terminal_ready_n, .chan_events,
        .chan_service_req, .chan_service_req_oe, .shared_req_n, .shared_req_oe);
    modem_model #(.NUM_CHAN(4)) far (.powered, .force_drv, .dataset_ready_n, .req_force_sel);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("Checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    // Expected {driver enable, request} of one channel in strobe mode
    function automatic logic [1:0] exp_req(input logic ctl3, input logic force_on,
        input logic [3:0] en, input logic [3:0] ev);
        exp_req = {force_on | ctl3, ctl3 & (|(en & ev))};
    endfunction : exp_req
    // One access: channel 0 strobe pins, or shared select with direction on the chan_addr channel
    task automatic xfer(input logic rd, input logic [2:0] a, input logic [7:0] d);
        reg_addr = a;
        data_in = d;
        host_wr_strobe_n = rd | bus_mode_strobe;
        chan_select_n[0] = ~bus_mode_strobe;
        cyc(3);
        if (!bus_mode_strobe) chan_select_n[0] = 1'b0;
        else if (rd) host_rd_strobe_n = 1'b0;
        else host_wr_strobe_n = 1'b0;
        cyc(4);
        q = data_out;
        if (rd) chk({7'h0, data_oe}, 8'h01);
        host_rd_strobe_n = 1'b1;
        if (bus_mode_strobe) host_wr_strobe_n = 1'b1;
        chan_select_n = 4'hf;
        cyc(4);
    endtask : xfer
    // Main sequence
    initial begin
        logic [7:0] d;
        logic [3:0] en;
        void'($urandom(22536));
        cyc(5);
        rst_n = 1'b1;
        cyc(6);
        chk({4'h0, terminal_ready_n}, 8'h0f);
        xfer(1'b1, MODEM_CTRL_OFS, 8'h00);
        chk(q, MODEM_CTRL_RST);
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 8'h01 : 8'($urandom);
            xfer(1'b0, MODEM_CTRL_OFS, d);
            chk({7'h0, terminal_ready_n[0]}, {7'h0, ~d[0]});
            xfer(1'b1, MODEM_CTRL_OFS, 8'h00);
            chk(q, d);
        end
        for (int p = 0; p < 2; p++) begin
            powered[0] = p[0];
            xfer(1'b1, MODEM_STAT_OFS, 8'h00);
            chk({7'h0, q[MSR_DATASET_READY_BIT]}, {7'h0, p[0]});
            chk({7'h0, terminal_ready_n[0]}, {7'h0, ~d[0]});
        end
        xfer(1'b0, MODEM_CTRL_OFS, 8'h08);
        for (int i = 0; i < 4; i++) begin
            en = 4'($urandom) ^ 4'(1 << i);
            xfer(1'b0, EVENT_ENABLE_OFS, {4'h0, en});
            chan_events[3:0] = 4'(1 << i);
            cyc(2);
            chk({6'h0, chan_service_req_oe[0], chan_service_req[0]},
                {6'h0, exp_req(1'b1, 1'b0, en, 4'(1 << i))});
            chan_events[3:0] = 4'h0;
            cyc(2);
            chk({7'h0, chan_service_req[0]}, 8'h00);
        end
        xfer(1'b0, EVENT_ENABLE_OFS, 8'h0f);
        xfer(1'b0, MODEM_CTRL_OFS, 8'h00);
        chan_events[3:0] = 4'h2;
        for (int f = 0; f < 2; f++) begin
            force_drv = f ? 1'b1 : 1'bz;
            cyc(4);
            chk({6'h0, chan_service_req_oe[0], chan_service_req[0]},
                {6'h0, exp_req(1'b0, f[0], 4'hf, 4'h2)});
        end
        bus_mode_strobe = 1'b0;
        cyc(6);
        chk({6'h0, shared_req_oe, shared_req_n}, 8'h02);
        chk({4'h0, chan_service_req_oe}, 8'h00);
        host_rd_strobe_n = 1'b0;
        cyc(5);
        chk({7'h0, data_oe}, 8'h00);
        host_rd_strobe_n = 1'b1;
        xfer(1'b0, MODEM_CTRL_OFS, 8'h01);
        chk({7'h0, terminal_ready_n[0]}, 8'h00);
        xfer(1'b1, MODEM_CTRL_OFS, 8'h00);
        chk(q, 8'h01);
        // Channel number picks the target in read/write-line mode
        chan_addr = 2'h1;
        xfer(1'b0, MODEM_CTRL_OFS, 8'h01);
        chk({4'h0, terminal_ready_n}, 8'h0c);
        stop_test();
    end
    // Hang guard
    initial begin
        #100000;
        error_cnt++;
        stop_test();
    end
endmodule : host_pins_top_tb
`default_nettype wire
